//--- rtl/sfc_map.svh
// Register offsets, field positions, reset values and timing counts of the chunk host.
// Assumes an 8-bit APB byte address and 32-bit data; included by rtl/sfc_host.sv.
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH

// Register byte offsets on APB
`define SFC_CTRL_OFS 8'h00
`define SFC_TXHDR_OFS 8'h04
`define SFC_STAT_OFS 8'h08
`define SFC_FOOT_OFS 8'h0C
`define SFC_FHDR_OFS 8'h10
`define SFC_TXMEM_OFS 8'h40
`define SFC_RXMEM_OFS 8'h80

// Control register bits
`define SFC_CTRL_START 0
`define SFC_CTRL_SIZE_LO 1
`define SFC_CTRL_SIZE_HI 2
`define SFC_CTRL_EN 3
`define SFC_SIZE_RST 2'h3

// Status register bits
`define SFC_ST_BUSY 0
`define SFC_ST_DONE 1
`define SFC_ST_FPAR 2
`define SFC_ST_HEADER_BAD_FLAG 3

// Chunk header and footer bit positions
`define SFC_H_SYNC1 31
`define SFC_H_ORDER 30
`define SFC_H_NO_RECEIVE_FLAG 29
`define SFC_H_VS_HI 23
`define SFC_H_VS_LO 22
`define SFC_H_DV 21
`define SFC_H_SV 20
`define SFC_H_SWO_HI 19
`define SFC_H_SWO_LO 16
`define SFC_H_EV 14
`define SFC_H_EBO_HI 13
`define SFC_H_EBO_LO 8
`define SFC_H_TSC_HI 7
`define SFC_H_TSC_LO 6
`define SFC_F_HEADER_BAD_FLAG 30

// Two-byte frame header fields
`define SFC_FH_PRIO 10
`define SFC_FH_EGR_HI 7
`define SFC_FH_EGR_LO 6
`define SFC_FH_TSPAR 3
`define SFC_FH_TSPRES 2
`define SFC_FH_PORT 0

// Serial clock half period in pclk cycles
`define SFC_SCLK_HALF 3'd4

`endif

//--- rtl/sfc_pkg.sv
// Types shared by the chunk transfer host.
// Assumes the constants of sfc_map.svh are included where needed.
package sfc_pkg;
	typedef logic [31:0] sfc_word_t;
	typedef enum logic [2:0] {
		SFC_IDLE = 3'b000,
		SFC_LEAD = 3'b001,
		SFC_LOW = 3'b010,
		SFC_HIGH = 3'b011,
		SFC_TAIL = 3'b100,
		SFC_GAP = 3'b101
	} sfc_state_e;
endpackage

//--- rtl/sfc_host.sv
// Host end of the chunk based full duplex SPI data link, with an APB register slave.
// Assumes pclk at 25 MHz; the device samples sdi on rising sclk and drives sdo on falling sclk.
`timescale 1ns/1ps
`include "sfc_map.svh"

// Rules of the document for this block, the device and software
// R1 - Frame header priority bit is composed as zero on transmit.
// R2 - Egress stamp select field passes through to device; device captures the stamp.
// R3 - Stamp included and stamp parity bits are composed as zero on transmit.
// R4 - Software clears the per-port ready mask to get frame interrupts; this block has no interrupt, software polls done.
// R5 - Receive words keep first serial byte in bits 31 to 24.
// R6 - Receive data is handled in whole 32-bit words only.
// R7 - Software enables transmit cut-through before sending cut-through frames.
// R8 - Device starts transmitting once its FIFO reaches the start level.
// R9 - Host must feed data faster than line rate; device flags under-run.
// R10 - Device discards register writes failing their CRC check.
// R11 - After CRC errors software clears FIFOs or repeats the write.
// R12 - Device flags a frame length write with data still outstanding.
// R13 - Transmit chunk sends 4-byte header first; receive footer follows payload.
// R14 - Chip select goes high between separate transactions.
// R15 - Payload size resets to 64 bytes and locks once transfers are enabled.
// R16 - Header bit 31 is driven one and the order bit zero.
// R17 - No-receive flag is passed from software, normally zero.
// R18 - Vendor bit 0 selects destination port; vendor bit 1 forced zero.
// R19 - Device uses the payload only when data valid is one.
// R20 - Start word offset is forced to zero unless start valid is set.
// R21 - End byte offset is forced to zero unless end valid is set.
// R22 - Header parity bit makes the whole header odd parity.
// R23 - Device reports a bad received header in the footer; host records it.
// R24 - Device drops payload of a chunk whose header parity fails.
module sfc_host
	import sfc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic sclk,
	output logic cs_n,
	output logic sdi,
	input wire logic sdo
);

	// Build the transmit chunk header from the software fields
	function automatic sfc_word_t build_hdr(input sfc_word_t f);
		sfc_word_t h;
		h = 32'h0000_0000;
		h[`SFC_H_SYNC1] = 1'b1; // [R16]
		h[`SFC_H_ORDER] = 1'b0; // [R16]
		h[`SFC_H_NO_RECEIVE_FLAG] = f[`SFC_H_NO_RECEIVE_FLAG]; // [R17]
		h[`SFC_H_VS_LO] = f[`SFC_H_VS_LO]; // [R18]
		h[`SFC_H_VS_HI] = 1'b0; // [R18]
		h[`SFC_H_DV] = f[`SFC_H_DV]; // [R19]
		h[`SFC_H_SV] = f[`SFC_H_SV];
		if (f[`SFC_H_SV]) begin
			h[`SFC_H_SWO_HI:`SFC_H_SWO_LO] = f[`SFC_H_SWO_HI:`SFC_H_SWO_LO]; // [R20]
		end
		h[`SFC_H_EV] = f[`SFC_H_EV];
		if (f[`SFC_H_EV]) begin
			h[`SFC_H_EBO_HI:`SFC_H_EBO_LO] = f[`SFC_H_EBO_HI:`SFC_H_EBO_LO]; // [R21]
		end
		h[`SFC_H_TSC_HI:`SFC_H_TSC_LO] = f[`SFC_H_TSC_HI:`SFC_H_TSC_LO]; // [R2]
		h[0] = ~^h[31:1]; // [R22]
		return h;
	endfunction

	// Payload words per chunk: 8, 16, 32 or 64 bytes
	function automatic logic [4:0] chunk_words(input logic [1:0] sel);
		return 5'd2 << sel;
	endfunction

	// Two-byte frame header as the host must send it
	function automatic sfc_word_t build_fhdr(input sfc_word_t f);
		sfc_word_t h;
		h = 32'h0000_0000;
		h[`SFC_FH_EGR_HI:`SFC_FH_EGR_LO] = f[`SFC_FH_EGR_HI:`SFC_FH_EGR_LO]; // [R2]
		h[`SFC_FH_PORT] = f[`SFC_FH_PORT];
		h[`SFC_FH_PRIO] = 1'b0; // [R1]
		h[`SFC_FH_TSPAR] = 1'b0; // [R3]
		h[`SFC_FH_TSPRES] = 1'b0; // [R3]
		return h;
	endfunction

	// Word slot of the transmit payload buffer; reads and writes share this decode
	// so that the two sides can never disagree about which addresses are buffer words
	function automatic logic is_tx_word(input logic [7:0] a);
		return (a[7:6] == 2'b01) && (a[1:0] == 2'b00);
	endfunction

	// Word slot of the receive payload buffer; unaligned addresses fall to the error path
	function automatic logic is_rx_word(input logic [7:0] a);
		return (a[7:6] == 2'b10) && (a[1:0] == 2'b00);
	endfunction

	sfc_state_e state;
	sfc_word_t tx_mem [0:15];
	sfc_word_t rx_mem [0:15];
	sfc_word_t hdr_fields;
	sfc_word_t fhdr_fields;
	sfc_word_t footer;
	sfc_word_t rx_shift;
	logic [1:0] size_sel;
	logic link_en;
	logic done_flag;
	logic fpar_flag;
	logic header_bad_flag_flag;
	logic [9:0] bit_cnt;
	logic [2:0] half_cnt;
	logic sdo_meta;
	logic sdo_sync;
	logic wr_acc;
	logic setup;
	logic start_req;
	logic [4:0] nwords;
	logic [9:0] last_bit;
	logic half_end;
	logic word_end;
	logic foot_done;
	sfc_word_t full_word;
	logic [4:0] tx_widx;
	logic tx_bit;
	logic [31:0] stat_word;
	sfc_word_t tx_hdr_word;

	assign setup = psel & ~penable;
	assign wr_acc = psel & penable & pready & pwrite;
	// START is refused until the link is enabled and while a chunk is still in flight
	assign start_req = wr_acc && (paddr == `SFC_CTRL_OFS) && pwdata[`SFC_CTRL_START]
		&& link_en && (state == SFC_IDLE); // [R7] [R12]
	assign nwords = chunk_words(size_sel);
	// Header word plus payload words; the last cell is one below (nwords + 1) * 32
	assign last_bit = {nwords, 5'h1F}; // [R13]
	// One built header serves both the serial side and the read-back
	assign tx_hdr_word = build_hdr(hdr_fields); // [R22]
	assign half_end = (half_cnt == 3'h1);
	assign word_end = (bit_cnt[4:0] == 5'h1F);
	assign full_word = {rx_shift[30:0], sdo_sync};
	// The footer's last bit closes the chunk, so flags are judged on the whole footer
	assign foot_done = (state == SFC_HIGH) && half_end && (bit_cnt == last_bit);
	assign stat_word = {28'h0, header_bad_flag_flag, fpar_flag, done_flag, state != SFC_IDLE};

	// Serial bit to send for a given position: header word first, then payload
	always_comb begin
		tx_widx = bit_cnt[9:5];
		if (tx_widx == 5'h00) begin
			tx_bit = tx_hdr_word[5'h1F - bit_cnt[4:0]]; // [R13]
		end else begin
			tx_bit = tx_mem[4'(tx_widx - 5'h01)][5'h1F - bit_cnt[4:0]];
		end
	end

	// The device output is asynchronous to pclk, so it passes two flops first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sdo_meta <= 1'b0;
			sdo_sync <= 1'b0;
		end else begin
			sdo_meta <= sdo;
			sdo_sync <= sdo_meta;
		end
	end

	// APB answer: data and ready are prepared in the setup cycle, no wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= 1'b0;
				prdata <= 32'h0000_0000;
				if (paddr == `SFC_CTRL_OFS) begin
					prdata <= {28'h0, link_en, size_sel, 1'b0};
				end else if (paddr == `SFC_TXHDR_OFS) begin
					prdata <= tx_hdr_word;
				end else if (paddr == `SFC_STAT_OFS) begin
					prdata <= stat_word;
				end else if (paddr == `SFC_FOOT_OFS) begin
					prdata <= footer;
				end else if (paddr == `SFC_FHDR_OFS) begin
					prdata <= build_fhdr(fhdr_fields);
				end else if (is_tx_word(paddr)) begin
					prdata <= tx_mem[paddr[5:2]];
				end else if (is_rx_word(paddr)) begin
					prdata <= rx_mem[paddr[5:2]]; // [R5] [R6]
				end else begin
					pslverr <= 1'b1;
				end
			end
		end
	end

	// Control fields; payload size freezes once the link is enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			size_sel <= `SFC_SIZE_RST; // [R15]
			link_en <= 1'b0;
			hdr_fields <= 32'h0000_0000;
			fhdr_fields <= 32'h0000_0000;
		end else if (wr_acc) begin
			if (paddr == `SFC_CTRL_OFS) begin
				if (!link_en) begin
					size_sel <= pwdata[`SFC_CTRL_SIZE_HI:`SFC_CTRL_SIZE_LO]; // [R15]
				end
				link_en <= link_en | pwdata[`SFC_CTRL_EN]; // Cleared only by reset [R15]
			end
			if (paddr == `SFC_TXHDR_OFS) begin
				hdr_fields <= pwdata;
			end
			if (paddr == `SFC_FHDR_OFS) begin
				fhdr_fields <= pwdata;
			end
		end
	end

	// Transmit payload buffer; writes during a chunk are dropped to keep it coherent.
	// The whole payload is staged before START, so the serial side never starves.
	always_ff @(posedge pclk) begin
		if (wr_acc && is_tx_word(paddr) && state == SFC_IDLE) begin
			tx_mem[paddr[5:2]] <= pwdata; // [R9]
		end
	end

	// Serial sequencer: lead, bit cells, tail, then a gap with chip select high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SFC_IDLE;
			half_cnt <= 3'h0;
			bit_cnt <= 10'h000;
			sclk <= 1'b0;
			cs_n <= 1'b1;
			sdi <= 1'b0;
		end else begin
			half_cnt <= half_end ? `SFC_SCLK_HALF : half_cnt - 3'h1;
			unique case (state)
				SFC_IDLE: begin
					half_cnt <= `SFC_SCLK_HALF;
					if (start_req) begin
						state <= SFC_LEAD;
						cs_n <= 1'b0;
						bit_cnt <= 10'h000;
					end
				end
				SFC_LEAD: begin
					sdi <= tx_bit;
					if (half_end) begin
						state <= SFC_LOW;
					end
				end
				SFC_LOW: begin
					if (half_end) begin
						sclk <= 1'b1; // Device samples sdi here
						state <= SFC_HIGH;
					end
				end
				SFC_HIGH: begin
					if (half_end) begin
						sclk <= 1'b0;
						if (bit_cnt == last_bit) begin
							state <= SFC_TAIL;
						end else begin
							bit_cnt <= bit_cnt + 10'h001;
							state <= SFC_LEAD;
						end
					end
				end
				SFC_TAIL: begin
					if (half_end) begin
						cs_n <= 1'b1; // [R14]
						sdi <= 1'b0;
						state <= SFC_GAP;
					end
				end
				SFC_GAP: begin
					if (half_end) begin
						state <= SFC_IDLE; // Chip select stays high for a half period [R14]
					end
				end
				default: begin
					state <= SFC_IDLE;
					cs_n <= 1'b1;
					sclk <= 1'b0;
				end
			endcase
		end
	end

	// Receive shift: payload words first, footer last; MSB first keeps byte order [R5] [R13]
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_shift <= 32'h0000_0000;
			footer <= 32'h0000_0000;
		end else if (state == SFC_HIGH && half_end) begin
			rx_shift <= full_word;
			if (word_end && bit_cnt[9:5] == nwords) begin
				footer <= full_word; // [R13]
			end
		end
	end

	// Receive payload store, a whole word at a time
	always_ff @(posedge pclk) begin
		if (state == SFC_HIGH && half_end && word_end && bit_cnt[9:5] < nwords) begin
			rx_mem[bit_cnt[8:5]] <= full_word; // [R6]
		end
	end

	// Sticky status; a new event wins over a write-one clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_flag <= 1'b0;
			fpar_flag <= 1'b0;
			header_bad_flag_flag <= 1'b0;
		end else begin
			if (wr_acc && paddr == `SFC_STAT_OFS) begin
				done_flag <= done_flag & ~pwdata[`SFC_ST_DONE];
				fpar_flag <= fpar_flag & ~pwdata[`SFC_ST_FPAR];
				header_bad_flag_flag <= header_bad_flag_flag & ~pwdata[`SFC_ST_HEADER_BAD_FLAG];
			end
			// No interrupt exists: software polls done, so there is no mask to clear.
			// A parity flag tells software to throw the received words away.
			if (foot_done) begin
				done_flag <= 1'b1; // [R4]
				if (^full_word == 1'b0) begin
					fpar_flag <= 1'b1; // Footer must carry odd parity [R11]
				end
				if (full_word[`SFC_F_HEADER_BAD_FLAG]) begin
					header_bad_flag_flag <= 1'b1; // Device rejected our header [R23] [R24]
				end
			end
		end
	end

endmodule // sfc_host

//--- tb/sfc_host_checker.sv
// Port assertions for the chunk host: APB answer timing and serial framing.
// Assumes it is bound onto sfc_host and sees only its ports.
`timescale 1ns/1ps
module sfc_host_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo
);
	logic sclk_q;
	logic [9:0] bitc;
	// Rising sclk count in one select window, so header bits can be found
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q <= 1'b0;
			bitc <= 10'h000;
		end else begin
			sclk_q <= sclk;
			bitc <= cs_n ? 10'h000 : bitc + 10'(sclk & ~sclk_q);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_answer_a:
		assert property (psel && !penable |=> pready) else $error("no answer after setup");
	apb_pulse_a:
		assert property (pready |=> !pready) else $error("pready too long");
	unmapped_err_a:
		assert property (psel && penable && paddr == 8'h14 |-> pslverr) else $error("no slverr");
	cs_gap_a:
		assert property ($rose(cs_n) |-> cs_n[*4]) else $error("select gap short");
	sclk_high_a:
		assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk) else $error("sclk high width");
	sdi_hold_a:
		assert property (sclk |-> $stable(sdi)) else $error("sdi moved in high");
	sync_bit_a:
		assert property ($rose(sclk) && bitc == 10'h000 |-> sdi) else $error("bit 31 not 1");
	order_bit_a:
		assert property ($rose(sclk) && bitc == 10'h001 |-> !sdi) else $error("order bit set");
	vendor_hi_a:
		assert property ($rose(sclk) && bitc == 10'h008 |-> !sdi) else $error("bit 23 set");
	chunk_len_a:
		assert property ($rose(cs_n) |-> bitc[4:0] == 5'h00 && bitc >= 10'h040)
			else $error("chunk length");
endmodule // sfc_host_checker
bind sfc_host sfc_host_checker u_sfc_host_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk), .cs_n(cs_n),
	.sdi(sdi), .sdo(sdo));

//--- tb/sfc_dev_model.sv
// Behavioural device end of the chunk link: samples sdi on rising sclk, drives sdo on falling.
// Assumes the bench gives the payload word count and a commanded fault code.
`timescale 1ns/1ps
module sfc_dev_model (
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic [1:0] err,
	input wire logic [4:0] words,
	output logic sdo
);
	logic [31:0] hdr, sh, w;
	logic [31:0] mem [0:15];
	logic acc;
	int k;
	// Payload words, then the footer; err 1 flags a bad header, err 2 spoils parity
	function automatic logic [31:0] ow(int j);
		logic [31:0] f;
		if (j < words) return 32'h81422400 | j;
		f = {1'b0, err == 2'h1, 30'h0};
		f[0] = ~^f[31:1] ^ (err == 2'h2);
		return f;
	endfunction
	initial begin
		sdo = 1'b0;
		k = 0;
		acc = 1'b0;
	end
	// First bit must be on the line before the first rising sclk
	always @(negedge cs_n) begin
		k = 0;
		w = ow(0);
		sdo = w[31];
	end
	// Header first, then payload kept only if valid and odd parity
	always @(posedge sclk) if (!cs_n) begin
		sh = {sh[30:0], sdi};
		k++;
		if (k % 32 == 0 && k == 32) begin
			hdr = sh;
			acc = sh[21] && (^sh); // Bad header leaves store unchanged
		end else if (k % 32 == 0 && acc) mem[k / 32 - 2] = sh; // Start level of one word
	end
	always @(negedge sclk) if (!cs_n) begin
		w = ow(k / 32);
		sdo = w[31 - k % 32];
	end
	// Released line shows the inverse of its last level
	always @(posedge cs_n) sdo = ~sdo;
endmodule // sfc_dev_model

//--- tb/testbench.sv
// Bench for the chunk host: APB stimulus, device model on the serial side.
// Assumes sfc_host, the device model and the checker bind are compiled first.
`timescale 1ns/1ps
`include "sfc_map.svh"
module testbench;
	logic pclk, presetn, psel, penable, pwrite, sdo, sclk, cs_n, sdi, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [1:0] derr;
	logic [4:0] dwords;
	int n_fail, compares, cyc;
	sfc_host u_sfc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
	sfc_dev_model u_sfc_dev_model (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .err(derr),
		.words(dwords), .sdo(sdo));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task stop_test();
		$display("fails %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Hang guard well above the longest run
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			stop_test();
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] x, input string m);
		compares++;
		if (g !== x) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask
	// One APB transfer; request held until pready is seen
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1); // Only the hang guard ends a missing answer
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task do_reset();
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	function automatic logic [31:0] exp_hdr(logic [31:0] f);
		logic [31:0] h;
		h = 32'h80000000;
		h[29] = f[29];
		h[22:20] = f[22:20];
		if (f[20]) h[19:16] = f[19:16];
		h[14] = f[14];
		if (f[14]) h[13:8] = f[13:8];
		h[7:6] = f[7:6];
		h[0] = ~^h[31:1];
		return h;
	endfunction
	task t_reset();
		do_reset();
		apb(1'b0, `SFC_CTRL_OFS, 32'h0);
		chk(32'(r[2:1]), 32'h3, "size reset");
		apb(1'b0, 8'h14, 32'h0);
		chk(32'(e), 32'h1, "unmapped");
	endtask
	task t_fhdr();
		apb(1'b1, `SFC_FHDR_OFS, 32'hFFFFFFFF);
		apb(1'b0, `SFC_FHDR_OFS, 32'h0);
		chk(32'({r[10], r[7:6], r[3:2], r[0]}), 32'h19, "frame header");
	endtask
	// Every stamp code, with forbidden bits set and offsets left dirty
	task t_hdr();
		logic [31:0] f;
		for (int j = 0; j < 4; j++) begin
			f = 32'h40AA2B00 | (j << 6) | (j % 2) * 32'h00500000 | (j / 2) * 32'h20004000;
			apb(1'b1, `SFC_TXHDR_OFS, f);
			apb(1'b0, `SFC_TXHDR_OFS, 32'h0);
			chk(r, exp_hdr(f), "tx header");
		end
	endtask
	// One chunk at size code sz with a commanded device fault
	task t_chunk(input logic [1:0] sz, input logic [1:0] er, input logic [31:0] f);
		int k;
		logic [31:0] ft;
		do_reset();
		derr <= er;
		dwords <= 5'(2 << sz);
		apb(1'b1, `SFC_CTRL_OFS, 32'(sz) << 1);
		for (int j = 0; j < (2 << sz); j++) apb(1'b1, `SFC_TXMEM_OFS + 8'(4 * j), 32'h3C000000 | j);
		apb(1'b1, `SFC_TXHDR_OFS, f);
		apb(1'b1, `SFC_CTRL_OFS, (32'(sz) << 1) | 32'h8);
		apb(1'b1, `SFC_CTRL_OFS, 32'h9);
		apb(1'b0, `SFC_CTRL_OFS, 32'h0);
		chk(32'(r[2:1]), 32'(sz), "size lock");
		k = 0;
		do begin
			apb(1'b0, `SFC_STAT_OFS, 32'h0);
			k++;
		end while (r[`SFC_ST_DONE] !== 1'b1 && k < 3000);
		chk(32'(r[3:1]), 32'(er == 2'h1) << 2 | 32'(er == 2'h2) << 1 | 32'h1, "status");
		chk(u_sfc_dev_model.hdr, exp_hdr(f), "sent header");
		chk(32'(u_sfc_dev_model.acc), 32'(f[21]), "dv");
		for (int j = 0; j < (2 << sz); j++) begin
			if (f[21]) chk(u_sfc_dev_model.mem[j], 32'h3C000000 | j, "tx word");
			apb(1'b0, `SFC_RXMEM_OFS + 8'(4 * j), 32'h0);
			chk(r, 32'h81422400 | j, "rx word");
		end
		ft = {1'b0, er == 2'h1, 30'h0};
		ft[0] = ~^ft[31:1] ^ (er == 2'h2);
		apb(1'b0, `SFC_FOOT_OFS, 32'h0);
		chk(r, ft, "footer");
		apb(1'b1, `SFC_STAT_OFS, 32'hE);
		apb(1'b0, `SFC_STAT_OFS, 32'h0);
		chk(32'(r[3:1]), 32'h0, "status clear");
	endtask
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		derr = 2'h0;
		dwords = 5'h02;
		n_fail = 0;
		compares = 0;
		cyc = 0;
		t_reset();
		t_fhdr();
		t_hdr();
		t_chunk(2'h0, 2'h1, 32'h00300000);
		t_chunk(2'h1, 2'h2, 32'h00204A00);
		t_chunk(2'h2, 2'h0, 32'h00000080);
		t_chunk(2'h3, 2'h0, 32'h006000C0);
		stop_test();
	end
endmodule // testbench
